// [rtl/cpu_halt_standby_control.sv]
// CPU-only halt standby controller: clock gating, wake decision, port hold.
// Assumes CPU and interrupt controller on sys_clk_i; pins pass through pin_sync.
`timescale 1ns/10ps
module cpu_halt_standby_control
  import halt_ctrl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic reset_pin_n_i,
  input wire logic nmi_pin_i,
  input wire irq_req_t irq_i,
  input wire cpu_state_t cpu_i,
  input wire timer_cfg_t timer_cfg_i,
  input wire logic [PORT_W-1:0] port_live_i,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic osc_en_o,
  output logic halted_o,
  output logic cpu_hold_o,
  output logic ram_write_block_o,
  output logic pin_reset_o,
  output wake_result_t wake_o,
  output logic watch_timer_run_o,
  output logic wdt2_run_o,
  output logic [PORT_W-1:0] port_o
);

  ////////////////////////////////////////////////////////////////////////
  // Types and state

  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_HALT,
    ST_WAKE
  } mode_t;

  typedef struct packed {
    mode_t mode;
    logic [PORT_W-1:0] port_hold;
    wake_result_t result;
    logic service_at_entry;
    logic service_nmi_at_entry;
    logic [PRIO_W-1:0] service_prio_at_entry;
    logic pin_reset;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [1:0] pins_sync;
  logic nmi_sync;
  logic reset_pin_n_sync;
  logic nmi_seen;
  logic any_wake;
  logic mask_beats_service;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .async_i({nmi_pin_i, !reset_pin_n_i}),
    .sync_o(pins_sync)
  );

  // Reset pin inverted so the cleared synchroniser reads idle
  assign nmi_sync = pins_sync[1];
  assign reset_pin_n_sync = !pins_sync[0];

  ////////////////////////////////////////////////////////////////////////
  // Priority helper

  // Lower number is higher priority
  function automatic logic prio_higher(input logic [PRIO_W-1:0] req, input logic [PRIO_W-1:0] cur);
    prio_higher = req < cur;
  endfunction : prio_higher

  ////////////////////////////////////////////////////////////////////////
  // Wake detection on the ungated clock

  assign nmi_seen = nmi_sync | irq_i.nmi_req;
  assign any_wake = nmi_seen | irq_i.mask_req;
  assign mask_beats_service = !state_reg.service_at_entry ||
    (!state_reg.service_nmi_at_entry && prio_higher(irq_i.mask_prio, state_reg.service_prio_at_entry));

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_next = state_reg;
    state_next.result = '0;
    state_next.result.action = WAKE_NONE;
    state_next.pin_reset = 1'b0;
    if (!reset_pin_n_sync) begin
      // Same sequence as ordinary reset
      state_next = '0;
      state_next.mode = ST_NORMAL;
      state_next.result.action = WAKE_NONE;
      state_next.pin_reset = 1'b1;
    end else begin
      unique case (state_reg.mode)
        ST_NORMAL: begin
          if (cpu_i.halt_insn) begin
            state_next.mode = ST_HALT;
            state_next.port_hold = port_live_i;
            state_next.service_at_entry = cpu_i.in_service;
            state_next.service_nmi_at_entry = cpu_i.in_service_nmi;
            state_next.service_prio_at_entry = cpu_i.service_prio;
          end
        end
        ST_HALT: begin
          if (any_wake) begin
            state_next.mode = ST_WAKE;
            state_next.result.wake = 1'b1;
            if (nmi_seen && !state_reg.service_nmi_at_entry) begin
              state_next.result.ack_nmi = 1'b1;
              state_next.result.action = WAKE_BRANCH;
            end else if (nmi_seen) begin
              state_next.result.action = WAKE_PENDING;
            end else if (!cpu_i.interrupts_enabled_state) begin
              state_next.result.action = WAKE_CONTINUE;
            end else if (mask_beats_service) begin
              state_next.result.ack_mask = 1'b1;
              state_next.result.action = WAKE_BRANCH;
            end else begin
              state_next.result.action = WAKE_PENDING;
            end
          end
        end
        ST_WAKE: begin
          state_next.mode = ST_NORMAL;
        end
        default: begin
          state_next.mode = ST_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign halted_o = state_reg.mode == ST_HALT;
  assign cpu_clk_en_o = !halted_o;
  assign periph_clk_en_o = 1'b1;
  assign osc_en_o = 1'b1;
  assign cpu_hold_o = halted_o;
  assign ram_write_block_o = halted_o;
  assign pin_reset_o = state_reg.pin_reset;
  assign wake_o = state_reg.result;
  assign port_o = halted_o ? state_reg.port_hold : port_live_i;
  assign watch_timer_run_o = !halted_o || timer_cfg_i.subclock_used || timer_cfg_i.watch_main_sel;
  assign wdt2_run_o = !halted_o || timer_cfg_i.subclock_used || timer_cfg_i.wdt2_main_sel;

endmodule : cpu_halt_standby_control

// [rtl/halt_ctrl_pkg.sv]
// Constants and carrier types for the CPU halt standby controller.
// Assumes one 20 MHz system clock and a synchronous active-high reset.
package halt_ctrl_pkg;

  localparam int unsigned PRIO_W = 3;
  localparam int unsigned PORT_W = 16;
  localparam logic [PRIO_W-1:0] PRIO_LOWEST = 3'h7;
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    WAKE_NONE,
    WAKE_BRANCH,
    WAKE_CONTINUE,
    WAKE_PENDING
  } wake_action_t;

  // Request from the interrupt controller
  typedef struct packed {
    logic nmi_req;
    logic mask_req;
    logic [PRIO_W-1:0] mask_prio;
  } irq_req_t;

  // CPU state seen at halt time
  typedef struct packed {
    logic halt_insn;
    logic interrupts_enabled_state;
    logic in_service;
    logic in_service_nmi;
    logic [PRIO_W-1:0] service_prio;
  } cpu_state_t;

  // Decision handed back to the CPU
  typedef struct packed {
    logic wake;
    logic ack_nmi;
    logic ack_mask;
    wake_action_t action;
  } wake_result_t;

  // Timer clocking choices
  typedef struct packed {
    logic subclock_used;
    logic watch_main_sel;
    logic wdt2_main_sel;
  } timer_cfg_t;

endpackage : halt_ctrl_pkg

// [rtl/pin_sync.sv]
// Two-flop synchroniser for a bus of asynchronous pins.
// Assumes a single receiving clock; first stage feeds only the second.
`timescale 1ns/10ps
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.stage1 = async_i;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.stage2;

endmodule : pin_sync

// [tb/cpu_side_model.sv]
// CPU side model: issues halt, then keeps a no-op gap.
// Driven by the bench on the system clock.
`timescale 1ns/10ps
module cpu_side_model (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic go_i,
  output logic halt_insn_o
);
  logic [2:0] nop_reg;
  assign halt_insn_o = go_i && nop_reg == 3'h0;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      nop_reg <= 3'h0;
    end else begin
      nop_reg <= halt_insn_o ? 3'h5 : nop_reg - 3'(nop_reg != 3'h0);
    end
  end
endmodule : cpu_side_model

// [tb/halt_ctrl_monitor.sv]
// Checker on the halt controller ports.
// Bound to the top module.
`timescale 1ns/10ps
module halt_ctrl_monitor
  import halt_ctrl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire irq_req_t irq_i,
  input wire cpu_state_t cpu_i,
  input wire timer_cfg_t timer_cfg_i,
  input wire logic cpu_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic osc_en_o,
  input wire logic halted_o,
  input wire logic cpu_hold_o,
  input wire logic ram_write_block_o,
  input wire wake_result_t wake_o,
  input wire logic watch_timer_run_o,
  input wire logic wdt2_run_o,
  input wire logic [PORT_W-1:0] port_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  property p_gate; halted_o |-> !cpu_clk_en_o && periph_clk_en_o && osc_en_o && cpu_hold_o && ram_write_block_o; endproperty
  a_gate: assert property (p_gate) else $error("gate");
  property p_enter; $rose(halted_o) |-> $past(cpu_i.halt_insn); endproperty
  a_enter: assert property (p_enter) else $error("enter");
  property p_port; halted_o && $past(halted_o) |-> $stable(port_o); endproperty
  a_port: assert property (p_port) else $error("port");
  property p_wake; halted_o && (irq_i.mask_req || irq_i.nmi_req) |=> !halted_o && cpu_clk_en_o && wake_o.wake; endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_nmi; wake_o.ack_nmi |-> wake_o.action == WAKE_BRANCH; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi");
  property p_pend; wake_o.action == WAKE_PENDING |-> !(wake_o.ack_mask || wake_o.ack_nmi); endproperty
  a_pend: assert property (p_pend) else $error("pend");
  property p_watch; halted_o |-> watch_timer_run_o == (timer_cfg_i.subclock_used || timer_cfg_i.watch_main_sel); endproperty
  a_watch: assert property (p_watch) else $error("watch");
  property p_wdt; halted_o |-> wdt2_run_o == (timer_cfg_i.subclock_used || timer_cfg_i.wdt2_main_sel); endproperty
  a_wdt: assert property (p_wdt) else $error("wdt2");
  c_ack: cover property (wake_o.ack_mask);
  c_nmi: cover property (wake_o.ack_nmi);
  c_pend: cover property (wake_o.action == WAKE_PENDING);
endmodule : halt_ctrl_monitor
bind cpu_halt_standby_control halt_ctrl_monitor mon (.*);

// [tb/tb_cpu_halt_standby_control.sv]
// Bench for the halt controller wake decisions.
// Uses the CPU side model and the bound checker.
`timescale 1ns/10ps
module tb_cpu_halt_standby_control;
  import halt_ctrl_pkg::*;
  logic sys_clk_i = 0, reset_i = 1, go = 0, halt_w, halted;
  irq_req_t irq_i = '0;
  cpu_state_t st = '0, cpu_w;
  timer_cfg_t cfg = '0;
  logic [31:0] seed = 32'hb36c;
  logic [PORT_W-1:0] port_o;
  logic [PORT_W-1:0] port_exp = '0;
  logic rst_pin_n = 1, nmi_pin = 0, pin_rst;
  wake_result_t wake_o, exp_q[$];
  int mismatches = 0, num_checks = 0, cyc = 0;
  assign cpu_w = {halt_w, st[5:0]};
  cpu_side_model cpu (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .go_i(go), .halt_insn_o(halt_w));
  cpu_halt_standby_control dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .reset_pin_n_i(rst_pin_n),
    .nmi_pin_i(nmi_pin), .irq_i(irq_i), .cpu_i(cpu_w), .timer_cfg_i(cfg), .port_live_i(seed[PORT_W-1:0]),
    .cpu_clk_en_o(), .periph_clk_en_o(), .osc_en_o(), .halted_o(halted), .cpu_hold_o(),
    .ram_write_block_o(), .pin_reset_o(pin_rst), .wake_o(wake_o), .watch_timer_run_o(), .wdt2_run_o(),
    .port_o(port_o));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic run(input logic ie, sv, sn, input logic [2:0] sp, input logic nm, mk,
    input logic [2:0] mp, input wake_result_t e, input logic pn = 1'b0);
    @(negedge sys_clk_i);
    st <= '{1'b0, ie, sv, sn, sp};
    cfg <= seed[18:16];
    go <= 1;
    @(negedge sys_clk_i);
    go <= 0;
    repeat (2) @(negedge sys_clk_i);
    check(16'(halted), 16'h1);
    check(16'(port_o), 16'(port_exp));
    exp_q.push_back(e);
    irq_i <= '{nm, mk, mp};
    nmi_pin <= pn;
    @(negedge sys_clk_i);
    irq_i <= '0;
    repeat (2) @(negedge sys_clk_i);
    nmi_pin <= 0;
    repeat (6) @(negedge sys_clk_i);
    check(16'(exp_q.size()), 16'h0);
    $display("Test end at %0t", $time);
  endtask : run
  ////////////////////////////////////////////////////////////
  initial forever #25 sys_clk_i = ~sys_clk_i;
  always @(negedge sys_clk_i) seed <= lfsr(seed);
  always @(posedge sys_clk_i) if (halt_w && !halted) port_exp <= seed[PORT_W-1:0];
  always @(posedge sys_clk_i) if (++cyc == 3000) begin
    mismatches++;
    summarize();
  end
  always @(negedge sys_clk_i) if (wake_o.wake === 1'b1) begin
    if (exp_q.size() == 0) check(16'(wake_o), 16'h0);
    else check(16'(wake_o), 16'(exp_q.pop_front()));
  end
  initial begin
    repeat (2) @(negedge sys_clk_i);
    reset_i <= 0;
    repeat (3) @(negedge sys_clk_i);
    check(16'(pin_rst), 16'h0);
    run(1, 0, 0, 0, 0, 1, 3, '{1, 0, 1, WAKE_BRANCH});
    run(0, 0, 0, 0, 0, 1, 0, '{1, 0, 0, WAKE_CONTINUE});
    run(1, 1, 0, 2, 0, 1, 5, '{1, 0, 0, WAKE_PENDING});
    run(1, 1, 0, 4, 0, 1, 4, '{1, 0, 0, WAKE_PENDING});
    run(1, 1, 0, 5, 0, 1, 2, '{1, 0, 1, WAKE_BRANCH});
    run(0, 0, 0, 0, 1, 0, 0, '{1, 1, 0, WAKE_BRANCH});
    run(1, 1, 0, 0, 1, 0, 0, '{1, 1, 0, WAKE_BRANCH});
    run(1, 1, 1, 0, 1, 0, 0, '{1, 0, 0, WAKE_PENDING});
    run(0, 0, 0, 0, 0, 0, 0, '{1, 1, 0, WAKE_BRANCH}, 1'b1);
    st <= '0;
    go <= 1;
    @(negedge sys_clk_i);
    go <= 0;
    check(16'(halted), 16'h1);
    rst_pin_n <= 0;
    repeat (3) @(negedge sys_clk_i);
    check(16'({halted, pin_rst}), 16'h1);
    rst_pin_n <= 1;
    repeat (6) @(negedge sys_clk_i);
    check(16'(pin_rst), 16'h0);
    $display("Test end at %0t", $time);
    summarize();
  end
endmodule : tb_cpu_halt_standby_control
